// ==== rtl/accel_event_pkg.sv ====
/*
 * Constants shared by the motion sensor event and status logic: register
 * addresses, field positions, reset values, step timing and pad sources.
 * Assumes a 25 MHz system clock; all users reference names with pkg::.
 */
package accel_event_pkg;
	// ==========================================================
	// timing
	localparam int CLK_MHZ           = 25;
	localparam int SLOW_STEP_US      = 10000;
	localparam int FAST_STEP_US      = 2500;
	localparam int SLOW_STEP_CYCLES  = SLOW_STEP_US * CLK_MHZ;
	localparam int FAST_STEP_CYCLES  = FAST_STEP_US * CLK_MHZ;
	localparam int DIV_W             = 18;
	localparam int DUR_W             = 8;

	// ==========================================================
	// register addresses
	localparam logic [6:0] ADDR_PAD_CTRL     = 7'h22;
	localparam logic [6:0] ADDR_FILTER_CLEAR = 7'h23;
	localparam logic [6:0] ADDR_STATUS       = 7'h27;
	localparam logic [6:0] ADDR_X            = 7'h29;
	localparam logic [6:0] ADDR_Y            = 7'h2B;
	localparam logic [6:0] ADDR_Z            = 7'h2D;
	localparam logic [6:0] ADDR_GEN_CFG      = 7'h30;
	localparam logic [6:0] ADDR_GEN_SRC      = 7'h31;
	localparam logic [6:0] ADDR_GEN_THS      = 7'h32;
	localparam logic [6:0] ADDR_GEN_DUR      = 7'h33;

	// ==========================================================
	// field positions and reset values
	localparam int PAD_POL_BIT      = 7;
	localparam int PAD_DRV_BIT      = 6;
	localparam int PAD_TWO_SEL_LSB  = 3;
	localparam int PAD_ONE_SEL_LSB  = 0;
	localparam int SEL_W            = 3;
	localparam int CFG_AOI_BIT      = 7;
	localparam int CFG_LIR_BIT      = 6;
	localparam int EVENT_W          = 6;
	localparam int SRC_IA_BIT       = 6;
	localparam int THS_COUNTER_RELEASE_MODE_BIT     = 7;
	localparam int THS_W            = 7;
	localparam int AXES             = 3;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// ==========================================================
	// pad source codes
	typedef enum logic [2:0] {
		SRC_OFF     = 3'b000,
		SRC_GEN_ONE = 3'b001,
		SRC_GEN_TWO = 3'b010,
		SRC_EITHER  = 3'b011,
		SRC_READY   = 3'b100
	} pad_source_t;
endpackage

// ==== rtl/event_duration_counter.sv ====
/*
 * Duration counter of one event generator: counts steps while the event holds, reports the limit.
 * Assumes step is a one-cycle enable at the output data rate.
 */
`timescale 1ns/1ps
module event_duration_counter #(
	parameter int W = accel_event_pkg::DUR_W
) (
	input  wire logic         clk,               // system clock
	input  wire logic         resetn,            // synchronous reset, active low
	input  wire logic         step,              // one step of the data rate
	input  wire logic         condition,         // combined event present
	input  wire logic         hold,              // freeze the count
	input  wire logic         release_decrement, // 1 decrement, 0 clear on release
	input  wire logic [W-1:0] limit,             // programmed duration
	output logic              reached            // condition held long enough
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// ==========================================================
	// count
	always_comb begin
		next_count = count;
		if (step && !hold) begin // RULE20
			if (condition) begin
				if (count < limit)
					next_count = count + W'(1);
			end else if (release_decrement) begin // RULE18
				if (count != '0)
					next_count = count - W'(1);
			end else begin
				next_count = '0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			count <= '0;
		else
			count <= next_count;
	end

	// limit 0 fires on the first qualifying sample
	assign reached = condition && (count >= limit); // RULE23
endmodule

// ==== rtl/accel_event_status.sv ====
/*
 * Event and status logic of a three-axis motion sensor: interrupt pad
 * control, filter clear strobe, sample status flags, axis sample registers
 * and event generator one with its duration counter.
 * Assumes the sensing chain presents samples on this clock and that the
 * serial protocol engine drives the register port with one-cycle strobes.
 */
// Summary of operation
// RULE1 - pads are active high when polarity bit is 0, active low when 1
// RULE2 - driver bit 0 gives push-pull pads, 1 gives open-drain pads
// RULE3 - each pad has its own three-bit source field, reset to 000
// RULE4 - source codes: off, generator one, two, either, data ready
// RULE5 - reading the filter clear address clears the filter; data meaningless
// RULE6 - per-axis overrun set when an unread sample is replaced
// RULE7 - combined overrun set when an unread sample set is replaced
// RULE8 - per-axis new sample flag set on fresh sample, zero after reset
// RULE9 - combined new sample flag set while a complete unread set is pending
// RULE10 - generator one combines enabled events by OR (0) or AND (1)
// RULE11 - latch bit holds request and source flags until source is read
// RULE12 - per-axis above enables allow events when magnitude exceeds threshold
// RULE13 - per-axis below enables allow events when magnitude is under threshold
// RULE14 - source holds an active flag set when events were generated
// RULE15 - source holds above and below flags for each axis, reset zero
// RULE16 - reading the source clears it and the generator one request
// RULE17 - threshold register low seven bits are the compare threshold
// RULE18 - threshold top bit: release clears (0) or decrements (1) the counter
// RULE19 - eight-bit duration counts 2.5 ms steps at 400 Hz, 10 ms at 100 Hz
// RULE20 - duration counter frozen while latched and event confirmed
// RULE21 - rate select 0 gives 100 Hz samples, 1 gives 400 Hz
// RULE22 - filter enable feeds filtered samples to generator one
// RULE23 - request asserts only after the condition lasts the programmed steps
// RULE24 - each axis register holds its latest sample at the data rate
`timescale 1ns/1ps
module accel_event_status #(
	parameter int SLOW_STEP_CYCLES = accel_event_pkg::SLOW_STEP_CYCLES,
	parameter int FAST_STEP_CYCLES = accel_event_pkg::FAST_STEP_CYCLES
) (
	input  wire logic       clk,                   // 25 MHz system clock
	input  wire logic       resetn,                // synchronous reset, active low
	input  wire logic [6:0] reg_addr,              // register address
	input  wire logic       reg_wr,                // write strobe, one cycle
	input  wire logic       reg_rd,                // read strobe, one cycle
	input  wire logic [7:0] reg_wdata,             // write data
	output logic      [7:0] reg_rdata,             // read data, next cycle
	input  wire logic       sample_rate_select,    // 0 100 Hz, 1 400 Hz
	input  wire logic       gen_one_filter_enable, // filtered data to generator one
	input  wire logic [7:0] raw_x,                 // unfiltered x sample
	input  wire logic [7:0] raw_y,                 // unfiltered y sample
	input  wire logic [7:0] raw_z,                 // unfiltered z sample
	input  wire logic [7:0] filtered_x,            // high-pass x sample
	input  wire logic [7:0] filtered_y,            // high-pass y sample
	input  wire logic [7:0] filtered_z,            // high-pass z sample
	input  wire logic       event_gen_two,         // request of generator two
	output logic            filter_clear,          // pulse, clears high-pass state
	output logic            sample_tick,           // pulse, new sample set taken
	output logic            irq_pad_one_out,       // pad one output level
	output logic            irq_pad_one_oe,        // pad one output enable
	output logic            irq_pad_two_out,       // pad two output level
	output logic            irq_pad_two_oe         // pad two output enable
);
	// ==========================================================
	// helpers
	function automatic logic pad_source_level(input logic [2:0] sel, input logic one,
			input logic two, input logic ready);
		pad_source_level = 1'b0;
		case (sel)
			accel_event_pkg::SRC_GEN_ONE: pad_source_level = one;
			accel_event_pkg::SRC_GEN_TWO: pad_source_level = two;
			accel_event_pkg::SRC_EITHER:  pad_source_level = one | two;
			accel_event_pkg::SRC_READY:   pad_source_level = ready;
			default:                      pad_source_level = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] magnitude(input logic [7:0] s);
		magnitude = s[7] ? (~s + 8'h01) : s;
	endfunction

	// ==========================================================
	// register port decode
	logic       rd_status;
	logic       rd_src;
	logic [2:0] rd_axis;
	assign rd_status  = reg_rd && (reg_addr == accel_event_pkg::ADDR_STATUS);
	assign rd_src     = reg_rd && (reg_addr == accel_event_pkg::ADDR_GEN_SRC); // RULE16
	assign rd_axis[0] = reg_rd && (reg_addr == accel_event_pkg::ADDR_X);
	assign rd_axis[1] = reg_rd && (reg_addr == accel_event_pkg::ADDR_Y);
	assign rd_axis[2] = reg_rd && (reg_addr == accel_event_pkg::ADDR_Z);

	// ==========================================================
	// control registers
	logic [7:0] pad_ctrl;
	logic [7:0] gen_cfg;
	logic [7:0] gen_ths;
	logic [7:0] gen_dur;
	logic [7:0] next_pad_ctrl;
	logic [7:0] next_gen_cfg;
	logic [7:0] next_gen_ths;
	logic [7:0] next_gen_dur;

	always_comb begin
		next_pad_ctrl = pad_ctrl;
		next_gen_cfg  = gen_cfg;
		next_gen_ths  = gen_ths;
		next_gen_dur  = gen_dur;
		if (reg_wr) begin
			unique case (reg_addr)
				accel_event_pkg::ADDR_PAD_CTRL: next_pad_ctrl = reg_wdata;
				accel_event_pkg::ADDR_GEN_CFG:  next_gen_cfg  = reg_wdata;
				accel_event_pkg::ADDR_GEN_THS:  next_gen_ths  = reg_wdata;
				accel_event_pkg::ADDR_GEN_DUR:  next_gen_dur  = reg_wdata;
				default:                        next_pad_ctrl = pad_ctrl;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			pad_ctrl <= accel_event_pkg::REG_RESET; // RULE3
			gen_cfg  <= accel_event_pkg::REG_RESET;
			gen_ths  <= accel_event_pkg::REG_RESET;
			gen_dur  <= accel_event_pkg::REG_RESET;
		end else begin
			pad_ctrl <= next_pad_ctrl;
			gen_cfg  <= next_gen_cfg;
			gen_ths  <= next_gen_ths;
			gen_dur  <= next_gen_dur;
		end
	end

	// ==========================================================
	// sample rate divider and sample capture
	logic [accel_event_pkg::DIV_W-1:0] div_count;
	logic [accel_event_pkg::DIV_W-1:0] next_div_count;
	logic [accel_event_pkg::DIV_W-1:0] div_last;
	logic                              next_tick;
	logic                              gen_step;
	logic [7:0]                        sample [accel_event_pkg::AXES];
	logic [7:0]                        gen_data [accel_event_pkg::AXES];
	logic [7:0]                        next_sample [accel_event_pkg::AXES];
	logic [7:0]                        next_gen_data [accel_event_pkg::AXES];
	logic [7:0]                        raw_in [accel_event_pkg::AXES];
	logic [7:0]                        filt_in [accel_event_pkg::AXES];

	assign raw_in[0]  = raw_x;
	assign raw_in[1]  = raw_y;
	assign raw_in[2]  = raw_z;
	assign filt_in[0] = filtered_x;
	assign filt_in[1] = filtered_y;
	assign filt_in[2] = filtered_z;

	// a rate change takes effect at once; a count already past the new last value wraps on the next cycle
	assign div_last = sample_rate_select ? // RULE21 RULE19
		accel_event_pkg::DIV_W'(FAST_STEP_CYCLES - 1) :
		accel_event_pkg::DIV_W'(SLOW_STEP_CYCLES - 1);

	always_comb begin
		next_tick      = (div_count >= div_last);
		next_div_count = next_tick ? '0 : div_count + accel_event_pkg::DIV_W'(1);
		for (int i = 0; i < accel_event_pkg::AXES; i++) begin
			next_sample[i]   = sample[i];
			next_gen_data[i] = gen_data[i];
			if (next_tick) begin
				next_sample[i]   = raw_in[i]; // RULE24
				next_gen_data[i] = gen_one_filter_enable ? filt_in[i] : raw_in[i]; // RULE22
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_count   <= '0;
			sample_tick <= 1'b0;
			gen_step    <= 1'b0;
			for (int i = 0; i < accel_event_pkg::AXES; i++) begin
				sample[i]   <= accel_event_pkg::REG_RESET;
				gen_data[i] <= accel_event_pkg::REG_RESET;
			end
		end else begin
			div_count   <= next_div_count;
			sample_tick <= next_tick;
			gen_step    <= sample_tick;
			for (int i = 0; i < accel_event_pkg::AXES; i++) begin
				sample[i]   <= next_sample[i];
				gen_data[i] <= next_gen_data[i];
			end
		end
	end

	// ==========================================================
	// sample status flags
	logic [2:0] new_sample;
	logic [2:0] overrun;
	logic       all_axes_new_sample;
	logic       all_axes_overrun;
	logic [2:0] next_new_sample;
	logic [2:0] next_overrun;
	logic       next_all_new;
	logic       next_all_overrun;
	logic       set_drained;
	logic [7:0] status_byte;

	// the set counts as read once a read leaves no axis pending
	assign set_drained = (|rd_axis) && ((new_sample & ~rd_axis) == 3'b000);

	always_comb begin
		for (int i = 0; i < accel_event_pkg::AXES; i++) begin
			next_new_sample[i] = next_tick | (new_sample[i] & ~rd_axis[i]); // RULE8
			next_overrun[i] = (next_tick & new_sample[i]) | (overrun[i] & ~rd_axis[i]); // RULE6
		end
		next_all_new     = next_tick | (all_axes_new_sample & ~set_drained); // RULE9
		next_all_overrun = (next_tick & all_axes_new_sample) | // RULE7
			(all_axes_overrun & ~set_drained);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			new_sample          <= 3'h0;
			overrun             <= 3'h0;
			all_axes_new_sample <= 1'b0;
			all_axes_overrun    <= 1'b0;
		end else begin
			new_sample          <= next_new_sample;
			overrun             <= next_overrun;
			all_axes_new_sample <= next_all_new;
			all_axes_overrun    <= next_all_overrun;
		end
	end

	assign status_byte = {all_axes_overrun, overrun[2], overrun[1], overrun[0],
		all_axes_new_sample, new_sample[2], new_sample[1], new_sample[0]};

	// ==========================================================
	// event generator one
	logic [5:0] axis_cond;
	logic [5:0] axis_enable;
	logic [5:0] axis_event;
	logic [7:0] threshold;
	logic       event_and_or_select;
	logic       request_latch_enable;
	logic       combined;
	logic       duration_met;
	logic [6:0] gen_src;
	logic [6:0] next_gen_src;
	logic       event_gen_one;

	assign event_and_or_select  = gen_cfg[accel_event_pkg::CFG_AOI_BIT];
	assign request_latch_enable = gen_cfg[accel_event_pkg::CFG_LIR_BIT];
	assign axis_enable          = gen_cfg[accel_event_pkg::EVENT_W-1:0];
	assign threshold = {1'b0, gen_ths[accel_event_pkg::THS_W-1:0]}; // RULE17

	// bit order per axis pair is above then below, z highest
	generate
		for (genvar a = 0; a < accel_event_pkg::AXES; a++) begin : g_axis
			assign axis_cond[2*a+1] = magnitude(gen_data[a]) > threshold; // RULE12
			assign axis_cond[2*a]   = magnitude(gen_data[a]) < threshold; // RULE13
		end
	endgenerate

	assign axis_event = axis_cond & axis_enable;
	// with no enables set, the AND form stays quiet rather than firing
	assign combined = event_and_or_select ? // RULE10
		((&(axis_cond | ~axis_enable)) && (|axis_enable)) : (|axis_event);

	event_duration_counter #(
		.W (accel_event_pkg::DUR_W)
	) u_duration (
		.clk               (clk),
		.resetn            (resetn),
		.step              (gen_step),
		.condition         (combined),
		.hold              (request_latch_enable && gen_src[accel_event_pkg::SRC_IA_BIT]),
		.release_decrement (gen_ths[accel_event_pkg::THS_COUNTER_RELEASE_MODE_BIT]),
		.limit             (gen_dur),
		.reached           (duration_met)
	);

	always_comb begin
		if (request_latch_enable) begin // RULE11
			// new events win over a read in the same cycle
			next_gen_src = rd_src ? 7'h00 : gen_src; // RULE16
			if (duration_met)
				next_gen_src = next_gen_src | {1'b1, axis_event}; // RULE14 RULE15
		end else begin
			next_gen_src = duration_met ? {1'b1, axis_event} : 7'h00; // RULE14 RULE15
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			gen_src <= 7'h00;
		else
			gen_src <= next_gen_src;
	end

	assign event_gen_one = gen_src[accel_event_pkg::SRC_IA_BIT];

	// ==========================================================
	// read data, filter clear and pads
	logic [7:0] next_rdata;
	logic       next_filter_clear;
	logic       pad_one_level;
	logic       pad_two_level;
	logic       pad_one_want;
	logic       pad_two_want;
	logic       irq_polarity_low;
	logic       pad_driver_type;
	logic [2:0] pad_one_source_select;
	logic [2:0] pad_two_source_select;

	assign irq_polarity_low      = pad_ctrl[accel_event_pkg::PAD_POL_BIT];
	assign pad_driver_type       = pad_ctrl[accel_event_pkg::PAD_DRV_BIT];
	assign pad_one_source_select = pad_ctrl[accel_event_pkg::PAD_ONE_SEL_LSB +: accel_event_pkg::SEL_W];
	assign pad_two_source_select = pad_ctrl[accel_event_pkg::PAD_TWO_SEL_LSB +: accel_event_pkg::SEL_W];

	always_comb begin
		next_rdata = reg_rdata;
		if (reg_rd) begin
			unique case (reg_addr)
				accel_event_pkg::ADDR_PAD_CTRL: next_rdata = pad_ctrl;
				accel_event_pkg::ADDR_STATUS:   next_rdata = status_byte;
				accel_event_pkg::ADDR_X:        next_rdata = sample[0];
				accel_event_pkg::ADDR_Y:        next_rdata = sample[1];
				accel_event_pkg::ADDR_Z:        next_rdata = sample[2];
				accel_event_pkg::ADDR_GEN_CFG:  next_rdata = gen_cfg;
				accel_event_pkg::ADDR_GEN_SRC:  next_rdata = {1'b0, gen_src};
				accel_event_pkg::ADDR_GEN_THS:  next_rdata = gen_ths;
				accel_event_pkg::ADDR_GEN_DUR:  next_rdata = gen_dur;
				default:                        next_rdata = accel_event_pkg::READ_NONE; // RULE5
			endcase
		end
		next_filter_clear = reg_rd && (reg_addr == accel_event_pkg::ADDR_FILTER_CLEAR); // RULE5
		pad_one_level = pad_source_level(pad_one_source_select, event_gen_one, // RULE4
			event_gen_two, all_axes_new_sample);
		pad_two_level = pad_source_level(pad_two_source_select, event_gen_one, // RULE4
			event_gen_two, all_axes_new_sample);
		pad_one_want = pad_one_level ^ irq_polarity_low; // RULE1
		pad_two_want = pad_two_level ^ irq_polarity_low; // RULE1
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			reg_rdata       <= accel_event_pkg::READ_NONE;
			filter_clear    <= 1'b0;
			irq_pad_one_out <= 1'b0;
			irq_pad_one_oe  <= 1'b1;
			irq_pad_two_out <= 1'b0;
			irq_pad_two_oe  <= 1'b1;
		end else begin
			reg_rdata       <= next_rdata;
			filter_clear    <= next_filter_clear;
			// open drain only ever pulls low; the high level is external
			irq_pad_one_out <= pad_driver_type ? 1'b0 : pad_one_want; // RULE2
			irq_pad_one_oe  <= pad_driver_type ? ~pad_one_want : 1'b1; // RULE2
			irq_pad_two_out <= pad_driver_type ? 1'b0 : pad_two_want; // RULE2
			irq_pad_two_oe  <= pad_driver_type ? ~pad_two_want : 1'b1; // RULE2
		end
	end
endmodule

// ==== test/irq_host_model.sv ====
/*
 * Host-side model of the two interrupt pads: resolves each pad wire against the board pull-up.
 * Assumes the device drives a pad only while its enable is high.
 */
`timescale 1ns/1ps
module irq_host_model (
	input  wire logic one_out,  // pad one level
	input  wire logic one_oe,   // pad one enable
	input  wire logic two_out,  // pad two level
	input  wire logic two_oe,   // pad two enable
	output logic      one_wire, // resolved pad one
	output logic      two_wire  // resolved pad two
);
	// ==========================================================
	// pad resolution
	// a released pad follows the pull-up, never the last driven level
	assign one_wire = one_oe ? one_out : 1'b1;
	assign two_wire = two_oe ? two_out : 1'b1;
endmodule

// ==== test/accel_event_status_assertions.sv ====
/*
 * Port checker for the event and status block: register port answers,
 * filter clear strobe, pad one drive modes and the sample tick.
 * Assumes single clock, synchronous active-low reset; bound to the top.
 */
`timescale 1ns/1ps
module accel_event_checker (
	input wire logic       clk,             // clock
	input wire logic       resetn,          // reset, active low
	input wire logic [6:0] reg_addr,        // address
	input wire logic       reg_wr,          // write strobe
	input wire logic       reg_rd,          // read strobe
	input wire logic [7:0] reg_wdata,       // write data
	input wire logic [7:0] reg_rdata,       // read data
	input wire logic       filter_clear,    // filter clear pulse
	input wire logic       sample_tick,     // sample pulse
	input wire logic       irq_pad_one_out, // pad one level
	input wire logic       irq_pad_one_oe   // pad one enable
);
	// ==========================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_clear_after_read; reg_rd && reg_addr == 7'h23 |=> filter_clear; endproperty
	a_clear_after_read: assert property (p_clear_after_read) else $error("no clear pulse");
	property p_clear_cause; filter_clear |-> $past(reg_rd) && $past(reg_addr) == 7'h23; endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("clear pulse without read");
	property p_clear_data; reg_rd && reg_addr == 7'h23 |=> reg_rdata == 8'h00; endproperty
	a_clear_data: assert property (p_clear_data) else $error("clear read data not zero");
	property p_unmapped; reg_rd && reg_addr == 7'h7F |=> reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
	property p_open_drain; !irq_pad_one_oe |-> !irq_pad_one_out; endproperty
	a_open_drain: assert property (p_open_drain) else $error("released pad drives level");
	property p_pol_low; reg_wr && reg_addr == 7'h22 && reg_wdata == 8'h80
		|-> ##[1:3] (irq_pad_one_out && irq_pad_one_oe); endproperty
	a_pol_low: assert property (p_pol_low) else $error("inactive low pad not high");
	property p_released; reg_wr && reg_addr == 7'h22 && reg_wdata == 8'hC0
		|-> ##[1:3] (!irq_pad_one_oe && !irq_pad_one_out); endproperty
	a_released: assert property (p_released) else $error("open drain pad not released");
	property p_off; reg_wr && reg_addr == 7'h22 && reg_wdata == 8'h00
		|-> ##[1:3] (!irq_pad_one_out && irq_pad_one_oe); endproperty
	a_off: assert property (p_off) else $error("off pad not driven low");
	property p_tick_pulse; sample_tick |=> !sample_tick [*3]; endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("sample tick too long");
endmodule

bind accel_event_status accel_event_checker chk_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.filter_clear(filter_clear), .sample_tick(sample_tick), .irq_pad_one_out(irq_pad_one_out),
	.irq_pad_one_oe(irq_pad_one_oe));

// ==== test/tb_accel_event_and_status_logic.sv ====
/*
 * Self-checking bench for the event and status block with short step counts.
 * Assumes the host pad model resolves pad wires; registers via strobes.
 */
`timescale 1ns/1ps
module tb_accel_event_and_status_logic;
	localparam int SLOW = 40;
	localparam int FAST = 10;
	logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rate = 1'b0, fen = 1'b0, gen_two = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00, raw_x = 8'h00, raw_y = 8'h00, raw_z = 8'h00;
	logic [7:0] flt_x = 8'h00, flt_y = 8'h00, flt_z = 8'h00, reg_rdata, r;
	logic filter_clear, sample_tick, p1o, p1e, p2o, p2e, pad_one, pad_two;
	logic [6:0] rst_list [7] = '{7'h27, 7'h22, 7'h29, 7'h30, 7'h31, 7'h32, 7'h33};
	logic [6:0] rw_list [4] = '{7'h22, 7'h30, 7'h32, 7'h33};
	logic [7:0] pc [3] = '{8'h80, 8'hC0, 8'h00};
	logic pe [3] = '{1'b1, 1'b1, 1'b0};
	int fails = 0, checks = 0, n;
	int seed = 32'hEA3EE338;

	always #20 clk = ~clk;

	accel_event_status #(.SLOW_STEP_CYCLES(SLOW), .FAST_STEP_CYCLES(FAST)) dut_u (.clk(clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.sample_rate_select(rate), .gen_one_filter_enable(fen), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
		.filtered_x(flt_x), .filtered_y(flt_y), .filtered_z(flt_z), .event_gen_two(gen_two),
		.filter_clear(filter_clear), .sample_tick(sample_tick), .irq_pad_one_out(p1o), .irq_pad_one_oe(p1e),
		.irq_pad_two_out(p2o), .irq_pad_two_oe(p2e));
	irq_host_model host_u (.one_out(p1o), .one_oe(p1e), .two_out(p2o), .two_oe(p2e),
		.one_wire(pad_one), .two_wire(pad_two));

	// ==========================================================
	// tasks
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input string name, input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(name, reg_rdata, exp);
	endtask
	task padc(input logic e1, input logic e2);
		@(negedge clk);
		chk("pad one", {7'h00, pad_one}, {7'h00, e1});
		chk("pad two", {7'h00, pad_two}, {7'h00, e2});
	endtask
	// returns four cycles after each tick so reads finish before the next
	task ticks(input int k);
		repeat (k) begin
			for (int i = 0; i < 200 && sample_tick !== 1'b1; i++) @(negedge clk);
			repeat (4) @(posedge clk);
		end
	endtask
	task period(output int p);
		while (sample_tick !== 1'b1) @(negedge clk);
		p = 0;
		do begin
			@(negedge clk);
			p++;
		end while (sample_tick !== 1'b1 && p < 200);
	endtask
	task set_raw(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		@(posedge clk);
		raw_x <= x;
		raw_y <= y;
		raw_z <= z;
	endtask
	task give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		fails++;
		give_verdict();
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		foreach (rst_list[i]) rdc("reset value", rst_list[i], 8'h00);
		$display("test reset values done");
		foreach (rw_list[i]) begin
			r = $random(seed);
			wr(rw_list[i], r);
			rdc("rw register", rw_list[i], r);
		end
		foreach (rw_list[i]) wr(rw_list[i], 8'h00);
		wr(7'h31, 8'hFF);
		rdc("source after write", 7'h31, 8'h00);
		rdc("unmapped", 7'h7F, 8'h00);
		rdc("filter clear data", 7'h23, 8'h00);
		chk("filter clear pulse", {7'h00, filter_clear}, 8'h01);
		$display("test register access done");
		for (int i = 0; i < 3; i++) begin
			wr(7'h22, pc[i]);
			repeat (3) @(posedge clk);
			padc(pe[i], pe[i]);
		end
		wr(7'h22, 8'h10);
		gen_two <= 1'b1;
		repeat (3) @(posedge clk);
		padc(1'b0, 1'b1);
		gen_two <= 1'b0;
		$display("test pads done");
		ticks(1);
		rdc("x clear", 7'h29, raw_x);
		rdc("y clear", 7'h2B, raw_y);
		rdc("z clear", 7'h2D, raw_z);
		set_raw($random(seed), $random(seed), $random(seed));
		wr(7'h22, 8'h20);
		ticks(1);
		padc(1'b0, 1'b1);
		rdc("status fresh", 7'h27, 8'h0F);
		rdc("x sample", 7'h29, raw_x);
		rdc("y sample", 7'h2B, raw_y);
		rdc("z sample", 7'h2D, raw_z);
		rdc("status read", 7'h27, 8'h00);
		ticks(2);
		rdc("status overrun", 7'h27, 8'hFF);
		rdc("x sample", 7'h29, raw_x);
		rdc("status x read", 7'h27, 8'hEE);
		$display("test sample status done");
		wr(7'h22, 8'h01);
		wr(7'h32, 8'h14);
		wr(7'h30, 8'h6A);
		set_raw(8'hCE, 8'h32, 8'h32);
		ticks(2);
		padc(1'b1, 1'b0);
		set_raw(8'h14, 8'h14, 8'h14);
		ticks(2);
		padc(1'b1, 1'b0);
		rdc("source latched", 7'h31, 8'h6A);
		rdc("source cleared", 7'h31, 8'h00);
		repeat (3) @(posedge clk);
		padc(1'b0, 1'b0);
		wr(7'h30, 8'h2A);
		fen <= 1'b1;
		flt_x <= 8'h32;
		flt_y <= 8'hCE;
		flt_z <= 8'h32;
		ticks(2);
		rdc("filtered source", 7'h31, 8'h6A);
		fen <= 1'b0;
		ticks(2);
		rdc("raw source", 7'h31, 8'h00);
		wr(7'h30, 8'h15);
		set_raw(8'h05, 8'hFB, 8'h05);
		ticks(2);
		rdc("below source", 7'h31, 8'h55);
		wr(7'h33, 8'h03);
		wr(7'h30, 8'hAA);
		set_raw(8'h32, 8'h32, 8'h14);
		ticks(3);
		rdc("and partial", 7'h31, 8'h00);
		set_raw(8'h32, 8'h32, 8'h32);
		ticks(2);
		rdc("duration pending", 7'h31, 8'h00);
		ticks(4);
		rdc("and complete", 7'h31, 8'h6A);
		wr(7'h22, 8'hC1);
		repeat (3) @(posedge clk);
		padc(1'b0, 1'b1);
		wr(7'h32, 8'h94);
		set_raw(8'h32, 8'h32, 8'h14);
		ticks(1);
		set_raw(8'h32, 8'h32, 8'h32);
		ticks(2);
		rdc("decrement release", 7'h31, 8'h6A);
		$display("test event generator done");
		period(n);
		chk("slow period", 8'(n), 8'(SLOW));
		ticks(1);
		rate <= 1'b1;
		period(n);
		period(n);
		chk("fast period", 8'(n), 8'(FAST));
		$display("test data rate done");
		give_verdict();
	end
endmodule
